// ===== verif/eblc_mem_model.sv
// Far-side memory: ends each data phase after a set wait.
// Assumes cycle_busy marks the data phase.
`timescale 1ns/1ps
`default_nettype none
module eblc_mem_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cycle_busy,
   input wire logic [3:0] wait_n,
   output logic cycle_done
);
   logic [3:0] cnt_q;
   always_ff @(posedge sys_clk) begin
      if (rst || !cycle_busy || cycle_done) begin
         cnt_q <= 4'h0;
         cycle_done <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         cycle_done <= (cnt_q == wait_n);
      end
   end
endmodule : eblc_mem_model
`default_nettype wire

// ===== verif/eblc_top_tb.sv
// Bench for the byte-lane control block.
// Assumes the memory model ends each cycle.
`timescale 1ns/1ps
`default_nettype none
module eblc_top_tb;
   import eblc_pkg::*;
   logic sys_clk = 0, rst = 1, st = 0, wr = 0, dn, dir, busy;
   logic [1:0] sz = 0, al = 0, tg = 0;
   logic [3:0] w = 0, bs;
   int n_mismatch = 0, n_tests = 0;
   always #50 sys_clk = ~sys_clk;
   eblc_top u_dut (.sys_clk(sys_clk), .rst(rst), .cycle_start(st), .cycle_done(dn),
      .cycle_write(wr), .cycle_size(sz), .cycle_addr_lo(al), .cycle_target(tg),
      .oe_read_dir(dir), .byte_lane_strobes(bs), .cycle_busy(busy));
   eblc_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .cycle_busy(busy),
      .wait_n(w), .cycle_done(dn));
   task automatic chk(string nm, logic [3:0] s, logic [3:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic final_report;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   task automatic cyc(logic w_, logic [1:0] s_, a_, t_, logic [3:0] e, wt, logic sp);
      int i;
      @(posedge sys_clk);
      {st, wr, sz, al, tg} <= {1'b1, w_, s_, a_, t_};
      w <= wt;
      @(posedge sys_clk);
      {st, sz, tg} <= {sp, ~s_, ~t_};
      for (i = 0; i < 12; i++) begin
         #1;
         if (busy !== 1'b1) break;
         chk("strobes", bs, e);
         if (t_ != EBLC_TGT_ONCHIP) chk("dir", {3'h0, dir}, {3'h0, w_});
         @(posedge sys_clk);
         st <= 1'b0;
      end
      chk("phase", i[3:0], wt + 4'h2);
      chk("idle", bs, 4'hf);
      chk("idle dir", {3'h0, dir}, 4'h1);
   endtask : cyc
   task automatic t_ext;
      for (int a = 0; a < 4; a++) begin
         cyc(a[0], EBLC_SIZE_BYTE, a[1:0], EBLC_TGT_EXT, ~(4'h1 << a), 0, 0);
         cyc(1, EBLC_SIZE_BYTE, a[1:0], EBLC_TGT_PERIPH, ~(4'h1 << a), 1, 0);
      end
      cyc(0, EBLC_SIZE_WORD, 0, EBLC_TGT_EXT, 4'hc, 2, 1);
      cyc(1, EBLC_SIZE_WORD, 2, EBLC_TGT_EXT, 4'h3, 0, 0);
      cyc(0, EBLC_SIZE_LONG, 1, EBLC_TGT_EXT, 4'h0, 3, 1);
   endtask : t_ext
   task automatic t_sdram;
      for (int a = 0; a < 4; a++)
         cyc(a[1], EBLC_SIZE_BYTE, a[1:0], EBLC_TGT_SDRAM, ~(4'h8 >> a), 1, 0);
      cyc(1, EBLC_SIZE_WORD, 0, EBLC_TGT_SDRAM, 4'h3, 0, 1);
      cyc(0, EBLC_SIZE_WORD, 2, EBLC_TGT_SDRAM, 4'hc, 2, 0);
      cyc(0, EBLC_SIZE_LONG, 3, EBLC_TGT_SDRAM, 4'h0, 0, 0);
   endtask : t_sdram
   task automatic t_reset;
      @(posedge sys_clk);
      {st, wr, sz, al, tg} <= {1'b1, 1'b1, EBLC_SIZE_LONG, 2'h0, EBLC_TGT_EXT};
      w <= 4'hf;
      @(posedge sys_clk);
      st <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("busy strobes", bs, 4'h0);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk("reset strobes", bs, 4'hf);
      chk("reset dir", {3'h0, dir}, 4'h1);
      chk("reset busy", {3'h0, busy}, 4'h0);
   endtask : t_reset
   task automatic t_none;
      cyc(0, EBLC_SIZE_LONG, 0, EBLC_TGT_ONCHIP, 4'hf, 1, 0);
      cyc(1, EBLC_SIZE_NONE, 0, EBLC_TGT_EXT, 4'hf, 0, 1);
   endtask : t_none
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      t_ext();
      t_sdram();
      t_reset();
      t_none();
      final_report();
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
endmodule : eblc_top_tb
`default_nettype wire

// ===== verilog/eblc_lane_decode.sv
// Lane decoder: access size and low address to active-high lane enables.
// Assumes lane 0 is D[7:0]; caller applies memory-type order and polarity.
`timescale 1ns/1ps
`default_nettype none
module eblc_lane_decode
   import eblc_pkg::*;
(
   input wire logic [1:0] size,
   input wire logic [1:0] addr_lo,
   output logic [3:0] lane_en
);
   wire [3:0] byte_en;
   wire [3:0] word_en;
   // Big-endian address: offset 0 is the most significant byte
   assign byte_en = 4'h8 >> addr_lo;
   assign word_en = addr_lo[1] ? 4'h3 : 4'hc;
   always_comb begin
      unique case (size)
         EBLC_SIZE_BYTE: lane_en = byte_en;
         EBLC_SIZE_WORD: lane_en = word_en;
         EBLC_SIZE_LONG: lane_en = 4'hf;
         EBLC_SIZE_NONE: lane_en = 4'h0;
      endcase
   end
endmodule : eblc_lane_decode
`default_nettype wire

// ===== verilog/eblc_pkg.sv
// Constants shared by the external bus byte-lane control block.
// Assumes a 32-bit external data bus with four byte lanes.
package eblc_pkg;
   localparam int unsigned EBLC_LANES = 4;
   localparam logic [3:0] EBLC_STROBES_IDLE = 4'hf;
   localparam logic EBLC_DIR_RESET = 1'b1;
   localparam logic EBLC_DIR_READ = 1'b0;
   localparam logic EBLC_DIR_WRITE = 1'b1;
   localparam logic [1:0] EBLC_SIZE_BYTE = 2'h0;
   localparam logic [1:0] EBLC_SIZE_WORD = 2'h1;
   localparam logic [1:0] EBLC_SIZE_LONG = 2'h2;
   localparam logic [1:0] EBLC_SIZE_NONE = 2'h3;
   localparam logic [1:0] EBLC_TGT_EXT = 2'h0;
   localparam logic [1:0] EBLC_TGT_SDRAM = 2'h1;
   localparam logic [1:0] EBLC_TGT_PERIPH = 2'h2;
   localparam logic [1:0] EBLC_TGT_ONCHIP = 2'h3;
   typedef enum logic [1:0] {
      EBLC_IDLE = 2'b01,
      EBLC_DATA = 2'b10
   } eblc_state_t;
endpackage : eblc_pkg

// ===== verilog/eblc_top.sv
// External bus byte-lane control: direction line and four byte-lane strobes.
// Assumes the bus sequencer gives a one-cycle start and a one-cycle done.
// Contract
// - Direction low on reads, high on writes to external memory or peripherals.
// - SRAM and peripheral strobes are active low per used byte.
// - Only strobes of bytes actually accessed are asserted; others stay inactive.
// - Strobes assert for on-chip peripherals, never for on-chip SRAM, cache, ROM.
// - SDRAM strobes act as byte masks; low marks a transferred byte.
// - Flash lane 0 is D[31:24], SDRAM lane 0 is D[7:0]; all-high none.
`timescale 1ns/1ps
`default_nettype none
module eblc_top
   import eblc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cycle_start,
   input wire logic cycle_done,
   input wire logic cycle_write,
   input wire logic [1:0] cycle_size,
   input wire logic [1:0] cycle_addr_lo,
   input wire logic [1:0] cycle_target,
   output logic oe_read_dir,
   output logic [3:0] byte_lane_strobes,
   output logic cycle_busy
);
   eblc_state_t state_q;
   eblc_state_t state_d;
   logic [3:0] strobes_q;
   logic [3:0] strobes_d;
   logic dir_q;
   logic dir_d;
   logic [3:0] lane_en;
   logic [3:0] lane_rev;
   logic [3:0] strobes_new;
   wire start_ok;
   wire end_cycle;
   wire is_sdram;
   wire lanes_on;

   eblc_lane_decode u_decode (
      .size(cycle_size),
      .addr_lo(cycle_addr_lo),
      .lane_en(lane_en)
   );

   // Strobe index n carries the lane mirror image for flash and SRAM
   genvar gi;
   generate
      for (gi = 0; gi < EBLC_LANES; gi++) begin : g_rev
         assign lane_rev[gi] = lane_en[EBLC_LANES - 1 - gi];
      end
   endgenerate

   assign start_ok = (state_q == EBLC_IDLE) && cycle_start;
   assign end_cycle = (state_q == EBLC_DATA) && cycle_done;
   assign is_sdram = (cycle_target == EBLC_TGT_SDRAM);
   assign lanes_on = (cycle_target != EBLC_TGT_ONCHIP);
   // SDRAM: index n is D[8n+7:8n] and 0 marks a transferred byte
   assign strobes_new = !lanes_on ? EBLC_STROBES_IDLE :
                        is_sdram ? ~lane_en : ~lane_rev;

   always_comb begin
      state_d = state_q;
      strobes_d = strobes_q;
      dir_d = dir_q;
      unique case (state_q)
         EBLC_IDLE: begin
            if (start_ok) begin
               state_d = EBLC_DATA;
               strobes_d = strobes_new;
               dir_d = cycle_write ? EBLC_DIR_WRITE : EBLC_DIR_READ;
            end
         end
         EBLC_DATA: begin
            if (cycle_done) begin
               state_d = EBLC_IDLE;
               strobes_d = EBLC_STROBES_IDLE;
               dir_d = EBLC_DIR_RESET;
            end
         end
         default: begin
            state_d = EBLC_IDLE;
            strobes_d = EBLC_STROBES_IDLE;
            dir_d = EBLC_DIR_RESET;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= EBLC_IDLE;
         strobes_q <= EBLC_STROBES_IDLE;
         dir_q <= EBLC_DIR_RESET;
      end else begin
         state_q <= state_d;
         strobes_q <= strobes_d;
         dir_q <= dir_d;
      end
   end

   assign oe_read_dir = dir_q;
   assign byte_lane_strobes = strobes_q;
   assign cycle_busy = (state_q == EBLC_DATA);

   sequence s_start_read;
      start_ok && !cycle_write;
   endsequence

   sequence s_hold_data;
      cycle_busy && $stable(byte_lane_strobes) && $stable(oe_read_dir);
   endsequence

   sequence s_start_flash;
      start_ok && lanes_on && !is_sdram;
   endsequence

   sequence s_start_sdram;
      start_ok && is_sdram;
   endsequence

   sequence s_start_word;
      start_ok && lanes_on && cycle_size == EBLC_SIZE_WORD;
   endsequence

   sequence s_idle_quiet;
      !cycle_busy && byte_lane_strobes == EBLC_STROBES_IDLE;
   endsequence

   chk_dir_read: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_read |=> !oe_read_dir)
      else $error("Direction not low during read");
   chk_dir_write: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_write |=> oe_read_dir)
      else $error("Direction not high during write");
   chk_long_all: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_size == EBLC_SIZE_LONG && lanes_on |=> byte_lane_strobes == 4'h0)
      else $error("Longword did not assert all strobes");
   chk_byte_one: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_size == EBLC_SIZE_BYTE && lanes_on
      |=> $countones(~byte_lane_strobes) == 1)
      else $error("Byte access strobed other than one lane");
   chk_onchip_none: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_target == EBLC_TGT_ONCHIP |=> byte_lane_strobes == EBLC_STROBES_IDLE)
      else $error("Strobes asserted for on-chip memory");
   chk_flash_msb: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && !is_sdram && lanes_on && cycle_size == EBLC_SIZE_BYTE
      && cycle_addr_lo == 2'h0 |=> byte_lane_strobes == 4'he)
      else $error("Flash byte 0 not on strobe 0");
   chk_sdram_msb: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && is_sdram && cycle_size == EBLC_SIZE_BYTE
      && cycle_addr_lo == 2'h0 |=> byte_lane_strobes == 4'h7)
      else $error("SDRAM byte 0 not on strobe 3");
   chk_hold_phase: assert property (@(posedge sys_clk) disable iff (rst)
      cycle_busy && !cycle_done |=> s_hold_data)
      else $error("Outputs changed during data phase");
   chk_end_idle: assert property (@(posedge sys_clk) disable iff (rst)
      end_cycle |=> byte_lane_strobes == EBLC_STROBES_IDLE && !cycle_busy)
      else $error("Strobes not released after cycle");

   // Lane order per byte offset and memory type
   chk_flash_byte1: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_flash ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h1)
      |=> byte_lane_strobes == 4'hd)
      else $error("Flash byte 1 not on strobe 1");
   chk_flash_byte2: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_flash ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h2)
      |=> byte_lane_strobes == 4'hb)
      else $error("Flash byte 2 not on strobe 2");
   chk_flash_byte3: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_flash ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h3)
      |=> byte_lane_strobes == 4'h7)
      else $error("Flash byte 3 not on strobe 3");
   chk_sdram_byte1: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_sdram ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h1)
      |=> byte_lane_strobes == 4'hb)
      else $error("SDRAM byte 1 not on strobe 2");
   chk_sdram_byte2: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_sdram ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h2)
      |=> byte_lane_strobes == 4'hd)
      else $error("SDRAM byte 2 not on strobe 1");
   chk_sdram_byte3: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_sdram ##0 (cycle_size == EBLC_SIZE_BYTE && cycle_addr_lo == 2'h3)
      |=> byte_lane_strobes == 4'he)
      else $error("SDRAM byte 3 not on strobe 0");
   chk_flash_word_hi: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_flash ##0 (cycle_size == EBLC_SIZE_WORD && !cycle_addr_lo[1])
      |=> byte_lane_strobes == 4'hc)
      else $error("Flash upper word on wrong strobes");
   chk_flash_word_lo: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_flash ##0 (cycle_size == EBLC_SIZE_WORD && cycle_addr_lo[1])
      |=> byte_lane_strobes == 4'h3)
      else $error("Flash lower word on wrong strobes");
   chk_sdram_word_hi: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_sdram ##0 (cycle_size == EBLC_SIZE_WORD && !cycle_addr_lo[1])
      |=> byte_lane_strobes == 4'h3)
      else $error("SDRAM upper word on wrong strobes");
   chk_sdram_word_lo: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_sdram ##0 (cycle_size == EBLC_SIZE_WORD && cycle_addr_lo[1])
      |=> byte_lane_strobes == 4'hc)
      else $error("SDRAM lower word on wrong strobes");
   chk_word_pair: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_word |=> $countones(~byte_lane_strobes) == 2)
      else $error("Word access strobed other than two lanes");
   chk_size_none: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_size == EBLC_SIZE_NONE |=> byte_lane_strobes == EBLC_STROBES_IDLE)
      else $error("Strobes asserted for empty access");
   chk_periph_on: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok && cycle_target == EBLC_TGT_PERIPH && cycle_size != EBLC_SIZE_NONE
      |=> byte_lane_strobes != EBLC_STROBES_IDLE)
      else $error("No strobes for on-chip peripheral");

   // Phase and idle behaviour
   chk_start_busy: assert property (@(posedge sys_clk) disable iff (rst)
      start_ok |=> cycle_busy)
      else $error("Data phase did not begin after start");
   chk_refuse_start: assert property (@(posedge sys_clk) disable iff (rst)
      cycle_busy && cycle_start && !cycle_done |=> cycle_busy)
      else $error("Start during data phase ended the cycle");
   chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !cycle_busy |-> byte_lane_strobes == EBLC_STROBES_IDLE)
      else $error("Strobes active outside data phase");
   chk_idle_dir: assert property (@(posedge sys_clk) disable iff (rst)
      !cycle_busy |-> oe_read_dir == EBLC_DIR_RESET)
      else $error("Direction not at idle level outside data phase");
   chk_done_idle: assert property (@(posedge sys_clk) disable iff (rst)
      !cycle_busy && !cycle_start |=> s_idle_quiet)
      else $error("Idle done pulse changed the outputs");
   chk_rst_idle: assert property (@(posedge sys_clk)
      rst |=> byte_lane_strobes == EBLC_STROBES_IDLE && oe_read_dir == EBLC_DIR_RESET
      && !cycle_busy)
      else $error("Outputs not idle after reset");
endmodule : eblc_top
`default_nettype wire
